// file: haptic_regs.sv
`include "seq_defs.svh"
// Function
// - Trigger starts playback at slot 0x03
// - After waveform, advance to next slot
// - Zero identifier ends the sequence
// - At most eight waveforms per trigger
// - Slot eight at 0x0A, RW, reset zero
// - Write to 0x0B pushes byte into FIFO
// - Page select at 0xFF, resets zero

// ----------------------------------------
// Stream FIFO
// ----------------------------------------
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output      logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output      logic             out_valid,
    input  wire logic             out_ready,
    output      logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    // One bit wider than the pointers so full and empty differ
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    chk_fifo_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
        cnt_q == (AW+1)'(DEPTH) |-> !push)
        else $error("fifo pushed while full");
endmodule : stream_fifo

// ----------------------------------------
// Register bank and sequence engine
// ----------------------------------------
module haptic_regs #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    input  wire seq_pkg::byte_t reg_addr,
    input  wire seq_pkg::byte_t reg_wdata,
    output      seq_pkg::byte_t reg_rdata,
    input  wire seq_pkg::byte_t slot_early_0,
    input  wire seq_pkg::byte_t slot_early_1,
    input  wire seq_pkg::byte_t slot_early_2,
    input  wire seq_pkg::byte_t slot_early_3,
    input  wire seq_pkg::byte_t slot_early_4,
    input  wire seq_pkg::byte_t slot_early_5,
    input  wire seq_pkg::byte_t slot_early_6,
    input  wire logic          play_trigger,
    output      logic          play_start,
    output      seq_pkg::byte_t play_id,
    output      seq_pkg::byte_t play_slot,
    input  wire logic          play_done,
    output      logic          play_busy,
    output      logic          stream_ready,
    output      logic          sample_valid,
    input  wire logic          sample_ready,
    output      seq_pkg::byte_t sample_data,
    output      seq_pkg::byte_t page_select
);
    import seq_pkg::*;

    // ----------------------------------------
    // Reset synchroniser
    // ----------------------------------------
    logic rst_meta_q;
    logic rst_n;
    // Asserts at once, releases on the second edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    byte_t slot_eight_q;
    byte_t stream_last_q;
    byte_t page_q;
    byte_t rdata_q;
    logic  fifo_in_ready;
    logic  push_stream;

    // Stream writes while the FIFO is full are dropped
    assign push_stream  = reg_wr && reg_addr == `ADDR_STREAM;
    assign stream_ready = fifo_in_ready;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_eight_q <= `RESET_BYTE;
        end else if (reg_wr && reg_addr == `ADDR_SLOT_EIGHT) begin
            slot_eight_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            page_q <= `RESET_BYTE;
        end else if (reg_wr && reg_addr == `ADDR_PAGE) begin
            page_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stream_last_q <= `RESET_BYTE;
        end else if (push_stream && fifo_in_ready) begin
            stream_last_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= `RESET_BYTE;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `ADDR_SLOT_EIGHT: rdata_q <= slot_eight_q;
                `ADDR_STREAM:     rdata_q <= stream_last_q;
                `ADDR_PAGE:       rdata_q <= page_q;
                default:          rdata_q <= `RESET_BYTE;
            endcase
        end
    end

    assign reg_rdata   = rdata_q;
    assign page_select = page_q;

    // ----------------------------------------
    // Stream path
    // ----------------------------------------
    stream_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (push_stream),
        .in_ready  (fifo_in_ready),
        .in_data   (reg_wdata),
        .out_valid (sample_valid),
        .out_ready (sample_ready),
        .out_data  (sample_data)
    );

    // ----------------------------------------
    // Sequence engine
    // ----------------------------------------
    play_state_t state_q;
    logic [2:0]  idx_q;
    byte_t       cur_id;
    byte_t       id_q;

    always_comb begin
        unique case (idx_q)
            3'h0: cur_id = slot_early_0;
            3'h1: cur_id = slot_early_1;
            3'h2: cur_id = slot_early_2;
            3'h3: cur_id = slot_early_3;
            3'h4: cur_id = slot_early_4;
            3'h5: cur_id = slot_early_5;
            3'h6: cur_id = slot_early_6;
            3'h7: cur_id = slot_eight_q;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= PLAY_IDLE;
            idx_q   <= 3'h0;
            id_q    <= `RESET_BYTE;
        end else begin
            unique case (state_q)
                PLAY_IDLE: if (play_trigger) begin
                    idx_q   <= 3'h0;
                    state_q <= PLAY_START;
                end
                PLAY_START: if (cur_id == 8'h00) begin
                    state_q <= PLAY_IDLE;
                end else begin
                    id_q    <= cur_id;
                    state_q <= PLAY_WAIT;
                end
                PLAY_WAIT: if (play_done) begin
                    if (idx_q == 3'(`NUM_SLOTS - 1)) begin
                        state_q <= PLAY_IDLE;
                    end else begin
                        idx_q   <= idx_q + 3'h1;
                        state_q <= PLAY_START;
                    end
                end
                // Unused state code falls back to idle
                default: state_q <= PLAY_IDLE;
            endcase
        end
    end

    // Start pulse only for a nonzero identifier
    assign play_start = state_q == PLAY_START && cur_id != 8'h00;
    assign play_id    = id_q;
    assign play_slot  = `ADDR_SLOT_FIRST + {5'h00, idx_q};
    assign play_busy  = state_q != PLAY_IDLE;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence seq_trigger_idle;
        state_q == PLAY_IDLE && play_trigger;
    endsequence

    sequence seq_zero_slot;
        state_q == PLAY_START && cur_id == 8'h00;
    endsequence

    sequence seq_last_done;
        state_q == PLAY_WAIT && play_done && idx_q == 3'h7;
    endsequence

    chk_start_first_slot: assert property (@(posedge clk) disable iff (!rst_n)
        seq_trigger_idle |=> play_slot == `ADDR_SLOT_FIRST)
        else $error("sequence did not start at first slot");
    chk_advance_slot: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == PLAY_WAIT && play_done && idx_q != 3'h7 |=> play_slot == $past(play_slot) + 8'h01)
        else $error("slot did not advance");
    chk_wait_holds: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == PLAY_WAIT && !play_done |=> state_q == PLAY_WAIT && play_slot == $past(play_slot))
        else $error("slot left before its waveform finished");
    chk_zero_stops: assert property (@(posedge clk) disable iff (!rst_n)
        seq_zero_slot |-> !play_start ##1 !play_busy)
        else $error("zero id did not end sequence");
    chk_eight_max: assert property (@(posedge clk) disable iff (!rst_n)
        seq_last_done |=> !play_busy)
        else $error("sequence ran past eighth slot");
    chk_slot_write: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == `ADDR_SLOT_EIGHT |=> slot_eight_q == $past(reg_wdata))
        else $error("slot eight write lost");
    chk_slot_read: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == `ADDR_SLOT_EIGHT |=> reg_rdata == $past(slot_eight_q))
        else $error("slot eight read wrong");
    chk_stream_push: assert property (@(posedge clk) disable iff (!rst_n)
        push_stream && fifo_in_ready && !sample_valid |=> sample_valid && sample_data == $past(reg_wdata))
        else $error("stream byte not queued");
    chk_full_drop: assert property (@(posedge clk) disable iff (!rst_n)
        push_stream && !fifo_in_ready |=> stream_last_q == $past(stream_last_q))
        else $error("stream byte taken while full");
    chk_page_write: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == `ADDR_PAGE |=> page_select == $past(reg_wdata))
        else $error("page write lost");
    chk_page_read: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == `ADDR_PAGE |=> reg_rdata == $past(page_q))
        else $error("page read wrong");
    chk_play_id: assert property (@(posedge clk) disable iff (!rst_n)
        play_start |=> play_id == $past(cur_id) && play_busy)
        else $error("played id mismatch");
    chk_id_held: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == PLAY_WAIT |=> play_id == $past(play_id))
        else $error("played id changed while waiting");
endmodule : haptic_regs

// file: seq_defs.svh
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH
`define ADDR_SLOT_FIRST  8'h03
`define ADDR_SLOT_SECOND 8'h04
`define ADDR_SLOT_EIGHT  8'h0A
`define ADDR_STREAM      8'h0B
`define ADDR_PAGE        8'hFF
`define NUM_SLOTS        8
`define RESET_BYTE       8'h00
`endif

// file: seq_pkg.sv
package seq_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        PLAY_IDLE,
        PLAY_START,
        PLAY_WAIT
    } play_state_t;
endpackage : seq_pkg

// file: play_sink.sv
// ----------------------------------------
// Playback side and sample sink
// ----------------------------------------
module play_sink
    import seq_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  play_start,
    input  wire byte_t play_slot,
    input  wire byte_t play_id,
    output      logic  play_done,
    input  wire logic  drain,
    output      logic  sample_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    byte_t slots[$];
    byte_t ids[$];

    // Stalls the FIFO output until the bench opens the drain
    assign sample_ready = drain;

    // Each waveform lasts three cycles, then completion is pulsed once
    initial begin
        play_done = 1'b0;
        forever begin
            @(posedge clk);
            if (play_start === 1'b1) begin
                slots.push_back(play_slot);
                // The identifier is registered, so it is taken half a cycle later, at the next falling edge
                @(negedge clk);
                ids.push_back(play_id);
                repeat (2) @(negedge clk);
                play_done = 1'b1;
                @(negedge clk);
                play_done = 1'b0;
            end
        end
    end
endmodule : play_sink

// file: haptic_regs_test.sv
`include "seq_defs.svh"
module haptic_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    import seq_pkg::*;
    logic  clk, nrst, reg_wr, reg_rd, play_trigger, play_start, play_done;
    logic  play_busy, stream_ready, sample_valid, sample_ready, drain;
    byte_t reg_addr, reg_wdata, reg_rdata, play_id, play_slot, sample_data, page_select;
    byte_t early [7];
    int    errors, n_compared;

    haptic_regs #(.FIFO_DEPTH(8)) dut (
        .clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .slot_early_0(early[0]),
        .slot_early_1(early[1]), .slot_early_2(early[2]), .slot_early_3(early[3]),
        .slot_early_4(early[4]), .slot_early_5(early[5]), .slot_early_6(early[6]),
        .play_trigger(play_trigger), .play_start(play_start), .play_id(play_id),
        .play_slot(play_slot), .play_done(play_done), .play_busy(play_busy),
        .stream_ready(stream_ready), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .sample_data(sample_data), .page_select(page_select));

    play_sink p (.clk(clk), .play_start(play_start), .play_slot(play_slot), .play_id(play_id),
                 .play_done(play_done), .drain(drain), .sample_ready(sample_ready));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task wr(input byte_t a, input byte_t d);
        @(negedge clk);
        reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr

    task rd(input byte_t a, output byte_t d);
        @(negedge clk);
        reg_rd = 1'b1; reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd

    task regs_test;
        byte_t d;
        rd(`ADDR_SLOT_EIGHT, d); check(d, 8'h00);
        rd(`ADDR_PAGE, d);       check(d, 8'h00);
        rd(`ADDR_STREAM, d);     check(d, 8'h00);
        check(page_select, 8'h00);
        wr(`ADDR_SLOT_EIGHT, 8'hA5);
        rd(`ADDR_SLOT_EIGHT, d); check(d, 8'hA5);
        wr(`ADDR_PAGE, 8'h3C);
        rd(`ADDR_PAGE, d);       check(d, 8'h3C);
        check(page_select, 8'h3C);
    endtask : regs_test

    task stream_test;
        byte_t d;
        for (int i = 0; i < 8; i++) wr(`ADDR_STREAM, 8'hA0 + 8'(i));
        check(stream_ready, 1'b0);
        wr(`ADDR_STREAM, 8'hEE);
        rd(`ADDR_STREAM, d); check(d, 8'hA7);
        drain = 1'b1;
        for (int i = 0; i < 8; i++) begin
            check(sample_valid, 1'b1);
            check(sample_data, 8'hA0 + 8'(i));
            @(negedge clk);
        end
        check(sample_valid, 1'b0);
        check(stream_ready, 1'b1);
        drain = 1'b0;
    endtask : stream_test

    task reset_test;
        byte_t d;
        @(negedge clk);
        nrst = 1'b0;
        repeat (3) @(negedge clk);
        check(page_select, 8'h00);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        rd(`ADDR_SLOT_EIGHT, d); check(d, 8'h00);
        rd(`ADDR_STREAM, d);     check(d, 8'h00);
        rd(`ADDR_PAGE, d);       check(d, 8'h00);
    endtask : reset_test

    task seq_test(input int stop);
        int n0;
        for (int k = 0; k < 7; k++) early[k] = (k == stop) ? 8'h00 : 8'h10 + 8'(k);
        wr(`ADDR_SLOT_EIGHT, (stop == 7) ? 8'h00 : 8'h55);
        n0 = p.slots.size();
        @(negedge clk);
        play_trigger = 1'b1;
        @(negedge clk);
        play_trigger = 1'b0;
        for (int t = 0; t < 300 && play_busy !== 1'b0; t++) @(negedge clk);
        check(play_busy, 1'b0);
        check(p.slots.size() - n0, stop);
        if (stop > 0) check(p.slots[n0], `ADDR_SLOT_FIRST);
        for (int i = 0; i < stop; i++) check(p.slots[n0 + i], 8'h03 + 8'(i));
        for (int i = 0; i < stop; i++) check(p.ids[n0 + i], (i < 7) ? 8'h10 + 8'(i) : 8'h55);
    endtask : seq_test

    task wrap_up;
        if (errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #200us;
        errors++;
        wrap_up;
    end

    initial begin
        errors = 0; n_compared = 0; nrst = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 8'h00; reg_wdata = 8'h00; play_trigger = 1'b0; drain = 1'b0;
        foreach (early[k]) early[k] = 8'h00;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        regs_test;
        stream_test;
        seq_test(0);
        seq_test(3);
        seq_test(7);
        seq_test(8);
        reset_test;
        wrap_up;
    end
endmodule : haptic_regs_test
